// ===== common/cg_pkg.sv
// Package of constants and types for the FLL clock generator configuration block.
package cg_pkg;
    // ****************************************
    // Register map and reset values
    // ****************************************
    localparam logic [2:0] ADDR_CTRL1 = 3'h0;
    localparam logic [2:0] ADDR_CTRL2 = 3'h1;
    localparam logic [2:0] ADDR_STAT1 = 3'h2;
    localparam logic [2:0] ADDR_STAT2 = 3'h3;
    localparam logic [2:0] ADDR_FILT_HI = 3'h4;
    localparam logic [2:0] ADDR_FILT_LO = 3'h5;
    localparam logic [2:0] ADDR_TRIM = 3'h6;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [11:0] FILTER_RST = 12'ha3e;
    localparam logic [7:0] TRIM_RST = 8'h80;
    // ****************************************
    // Status field positions
    // ****************************************
    localparam int S1_MODE_HI = 7;
    localparam int S1_MODE_LO = 6;
    localparam int S1_REF_EXT = 5;
    localparam int S1_CLK_LOST = 4;
    localparam int S1_LOCKED = 3;
    localparam int S1_LOCK_LOST = 2;
    localparam int S1_IRQ = 0;
    localparam int S2_OSC_STABLE = 0;
    // ****************************************
    // Clock mode codes
    // ****************************************
    localparam logic [1:0] MODE_SELF = 2'h0;
    localparam logic [1:0] MODE_LPINT = 2'h1;
    localparam logic [1:0] MODE_BYPX = 2'h2;
    localparam logic [1:0] MODE_LPEXT = 2'h3;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 50;
    localparam int IREF_KHZ = 243;
    localparam int IREF_NOM_CYC = CLK_MHZ * 1000 / IREF_KHZ;
    localparam int IREF_DIV = 7;
    localparam int PRESCALE_LOW = 64;
    localparam int PRESCALE_HIGH = 1;
    localparam int LOC_TIME_US = 200;
    localparam int LOC_CYC = LOC_TIME_US * CLK_MHZ;
    localparam int MODE_SETTLE_CYC = 4;
    localparam int LOCK_TOL = 4;
    localparam int OSC_STABLE_EDGES = 16;
    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic gain_hi;
        logic range_hi;
        logic ext_sel;
        logic [1:0] mode_sel;
        logic osc_keep;
        logic loss_off;
        logic unused0;
    } cg_ctrl1_s;
    typedef struct packed {
        logic lock_rst_en;
        logic [2:0] mul_code;
        logic loss_rst_en;
        logic [2:0] div_code;
    } cg_ctrl2_s;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cg_bus_s;
    typedef enum logic [0:0] {
        SETTLE_IDLE,
        SETTLE_WAIT
    } cg_settle_e;
endpackage

// ===== verilog/cg_fll_clock_gen.sv
// FLL clock generator: configuration registers, digital DCO model, loop and status.
// Operation
// - After reset run self-clocked, about 8 MHz out and 4 MHz bus.
// - Control one bit 7 selects oscillator gain; 0 means low power.
// - Control one bit 6 picks range; 0 gives prescale 64, 1 gives 1 in external loop mode only.
// - Control one bit 5 set requests the crystal oscillator as reference.
// - Control one bits 4:3 pick mode; 11 external loop, 01 internal loop.
// - Control one bit 2 clear lets the oscillator be disabled.
// - Control one bit 1 clear keeps loss-of-clock detection active.
// - Control one bit 0 always reads zero.
// - Control two bit 7 clear makes lock loss raise an interrupt request.
// - Control two bits 6:4 give multiplier; 000 is 4, 011 is 10.
// - Control two bit 3 clear makes clock loss raise an interrupt request.
// - Control two bits 2:0 give divider; 000 is 1, 001 is 2.
// - External loop output equals reference times P times N over R.
// - Internal loop output equals internal reference over 7, times 64, N, over R.
// - Status one is read only; writing 1 to its interrupt flag clears it and both loss flags.
// - Filter holds 12 bits, top four read zero; loop adjusts it when engaged.
// - Trim holds 8 bits adjusting only the internal oscillator.
// - Untrimmed internal reference period stays within 25 percent of nominal.
// - Multiplier codes 100-111 give 12-18; divider codes 010-111 give 4-128.
// - Gain select takes only one write after reset.
// - Mode status follows a new mode select only after several cycles.
`timescale 1ns/1ns
`default_nettype none
module cg_fll_clock_gen
    import cg_pkg::*;
#(
    parameter int LOC_TIMEOUT = LOC_CYC,
    parameter int ACC_W = 16
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic ext_ref_pin,
    output logic generator_output_clock,
    output logic bus_clock,
    output logic oscillator_enable,
    output logic high_gain_select,
    output logic osc_range_high,
    output logic irq_req,
    output logic reset_req
);
    // ****************************************
    // Decode functions
    // ****************************************
    function automatic logic [4:0] mult_factor(input logic [2:0] code);
        mult_factor = 5'(4 + 2 * int'(code));
    endfunction

    function automatic logic [7:0] div_factor(input logic [2:0] code);
        div_factor = 8'h01 << code;
    endfunction

    // ****************************************
    // Register bus
    // ****************************************
    cg_bus_s bus;
    cg_ctrl1_s ctrl1_ff;
    cg_ctrl2_s ctrl2_ff;
    logic gain_written_ff;
    logic [11:0] filter_ff;
    logic [7:0] trim_ff;
    logic [7:0] rdata_ff;
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic wr_c1;
    logic wr_c2;
    logic wr_s1;

    assign bus = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};
    assign wr_c1 = ce && bus.wr && bus.addr == ADDR_CTRL1;
    assign wr_c2 = ce && bus.wr && bus.addr == ADDR_CTRL2;
    assign wr_s1 = ce && bus.wr && bus.addr == ADDR_STAT1;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl1_ff <= cg_ctrl1_s'(CTRL1_RST);
            gain_written_ff <= 1'b0;
        end else if (wr_c1) begin
            ctrl1_ff.range_hi <= bus.wdata[6];
            ctrl1_ff.ext_sel <= bus.wdata[5];
            ctrl1_ff.mode_sel <= bus.wdata[4:3];
            ctrl1_ff.osc_keep <= bus.wdata[2];
            ctrl1_ff.loss_off <= bus.wdata[1];
            ctrl1_ff.unused0 <= 1'b0;
            gain_written_ff <= 1'b1;
            if (!gain_written_ff) begin
                ctrl1_ff.gain_hi <= bus.wdata[7];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl2_ff <= cg_ctrl2_s'(CTRL2_RST);
        end else if (wr_c2) begin
            ctrl2_ff <= cg_ctrl2_s'(bus.wdata);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            trim_ff <= TRIM_RST;
        end else if (ce && bus.wr && bus.addr == ADDR_TRIM) begin
            trim_ff <= bus.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 8'h00;
        end else if (ce && bus.rd) begin
            case (bus.addr)
                ADDR_CTRL1: rdata_ff <= {ctrl1_ff[7:1], 1'b0};
                ADDR_CTRL2: rdata_ff <= ctrl2_ff;
                ADDR_STAT1: rdata_ff <= stat1;
                ADDR_STAT2: rdata_ff <= stat2;
                ADDR_FILT_HI: rdata_ff <= {4'h0, filter_ff[11:8]};
                ADDR_FILT_LO: rdata_ff <= filter_ff[7:0];
                ADDR_TRIM: rdata_ff <= trim_ff;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    assign rdata = rdata_ff;

    // ****************************************
    // Mode status settling
    // ****************************************
    cg_settle_e settle_ff;
    logic [2:0] settle_cnt_ff;
    logic [1:0] mode_ff;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            settle_ff <= SETTLE_IDLE;
            settle_cnt_ff <= 3'h0;
            mode_ff <= MODE_SELF;
        end else if (ce) begin
            case (settle_ff)
                SETTLE_IDLE: begin
                    if (ctrl1_ff.mode_sel != mode_ff) begin
                        settle_ff <= SETTLE_WAIT;
                        settle_cnt_ff <= 3'h0;
                    end
                end
                SETTLE_WAIT: begin
                    if (settle_cnt_ff == 3'(MODE_SETTLE_CYC - 1)) begin
                        mode_ff <= ctrl1_ff.mode_sel;
                        settle_ff <= SETTLE_IDLE;
                    end else begin
                        settle_cnt_ff <= settle_cnt_ff + 3'h1;
                    end
                end
                default: settle_ff <= SETTLE_IDLE;
            endcase
        end
    end

    // ****************************************
    // External reference synchroniser
    // ****************************************
    logic ext_s1_ff;
    logic ext_s2_ff;
    logic ext_s3_ff;
    logic ext_rise;
    logic ext_edge;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end else if (ce) begin
            ext_s1_ff <= ext_ref_pin;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end

    assign ext_rise = ext_s2_ff && !ext_s3_ff;
    assign ext_edge = ext_s2_ff != ext_s3_ff;

    // ****************************************
    // Internal reference, trimmed
    // ****************************************
    localparam int IREF_W = 10;
    logic [IREF_W-1:0] iref_cnt_ff;
    logic [IREF_W-1:0] iref_period;
    logic iref_tick;
    logic [2:0] iref_div_ff;
    logic int_window;

    // Trim spans about +-15 percent around nominal, inside the guaranteed band.
    assign iref_period = IREF_W'(IREF_NOM_CYC - 32) + IREF_W'(trim_ff[7:2]);
    assign iref_tick = iref_cnt_ff == iref_period - IREF_W'(1);
    assign int_window = iref_tick && iref_div_ff == 3'(IREF_DIV - 1);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            iref_cnt_ff <= '0;
            iref_div_ff <= 3'h0;
        end else if (ce) begin
            iref_cnt_ff <= iref_tick ? '0 : iref_cnt_ff + IREF_W'(1);
            if (int_window) begin
                iref_div_ff <= 3'h0;
            end else if (iref_tick) begin
                iref_div_ff <= iref_div_ff + 3'h1;
            end
        end
    end

    // ****************************************
    // Digital DCO
    // ****************************************
    logic [ACC_W-1:0] acc_ff;
    logic [ACC_W-1:0] nxt_acc;
    logic dco_tick;

    assign nxt_acc = acc_ff + ACC_W'({filter_ff, 2'b00});
    assign dco_tick = nxt_acc[ACC_W-1] != acc_ff[ACC_W-1];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            acc_ff <= '0;
        end else if (ce) begin
            acc_ff <= nxt_acc;
        end
    end

    // ****************************************
    // Frequency locked loop
    // ****************************************
    logic engaged;
    logic window_end;
    logic [12:0] tick_cnt_ff;
    logic [12:0] target;
    logic [6:0] prescale;
    logic signed [14:0] err;
    logic locked_ff;
    logic lock_lost_evt;

    assign engaged = mode_ff == MODE_LPEXT || mode_ff == MODE_LPINT;
    assign prescale = (mode_ff == MODE_LPEXT && ctrl1_ff.range_hi) ? 7'(PRESCALE_HIGH) : 7'(PRESCALE_LOW);
    // Two ticks per DCO period, so the window target is twice P times N.
    assign target = 13'(2 * int'(prescale) * int'(mult_factor(ctrl2_ff.mul_code)));
    assign window_end = (mode_ff == MODE_LPEXT) ? ext_rise : int_window;
    assign err = 15'(signed'({2'b00, tick_cnt_ff})) - 15'(signed'({2'b00, target}));

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_ff <= '0;
        end else if (ce) begin
            if (window_end) begin
                tick_cnt_ff <= 13'(dco_tick);
            end else if (dco_tick && tick_cnt_ff != 13'h1fff) begin
                tick_cnt_ff <= tick_cnt_ff + 13'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            filter_ff <= FILTER_RST;
        end else if (ce) begin
            if (engaged && window_end) begin
                if (err < 0 && filter_ff != 12'hfff) begin
                    filter_ff <= filter_ff + 12'h1;
                end else if (err > 0 && filter_ff != 12'h000) begin
                    filter_ff <= filter_ff - 12'h1;
                end
            end else if (!engaged && bus.wr && bus.addr == ADDR_FILT_HI) begin
                filter_ff[11:8] <= bus.wdata[3:0];
            end else if (!engaged && bus.wr && bus.addr == ADDR_FILT_LO) begin
                filter_ff[7:0] <= bus.wdata;
            end
        end
    end

    assign lock_lost_evt = ce && engaged && window_end && locked_ff && (err > LOCK_TOL || err < -LOCK_TOL);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            locked_ff <= 1'b0;
        end else if (ce) begin
            if (!engaged) begin
                locked_ff <= 1'b0;
            end else if (window_end) begin
                locked_ff <= err <= LOCK_TOL && err >= -LOCK_TOL;
            end
        end
    end

    // ****************************************
    // Oscillator stability and loss of clock
    // ****************************************
    localparam int LOC_W = $clog2(LOC_TIMEOUT + 1);
    logic [LOC_W-1:0] loc_cnt_ff;
    logic [4:0] stable_cnt_ff;
    logic osc_stable;
    logic ext_used;
    logic clk_lost_evt;

    assign ext_used = ctrl1_ff.ext_sel && ctrl1_ff.mode_sel[1];
    assign osc_stable = stable_cnt_ff == 5'(OSC_STABLE_EDGES);
    assign clk_lost_evt = ce && ext_used && !ctrl1_ff.loss_off && loc_cnt_ff == LOC_W'(LOC_TIMEOUT - 1);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            loc_cnt_ff <= '0;
            stable_cnt_ff <= 5'h00;
        end else if (ce) begin
            if (ext_rise || !ext_used) begin
                loc_cnt_ff <= '0;
            end else if (loc_cnt_ff != LOC_W'(LOC_TIMEOUT)) begin
                loc_cnt_ff <= loc_cnt_ff + LOC_W'(1);
            end
            if (!oscillator_enable || clk_lost_evt) begin
                stable_cnt_ff <= 5'h00;
            end else if (ext_rise && !osc_stable) begin
                stable_cnt_ff <= stable_cnt_ff + 5'h01;
            end
        end
    end

    // ****************************************
    // Events, status flags and requests
    // ****************************************
    logic clk_lost_ff;
    logic lock_lost_ff;
    logic irq_ff;
    logic reset_req_ff;
    logic clr_irq;

    assign clr_irq = wr_s1 && bus.wdata[S1_IRQ];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clk_lost_ff <= 1'b0;
            lock_lost_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else if (ce) begin
            if (clk_lost_evt) begin
                clk_lost_ff <= 1'b1;
            end else if (clr_irq) begin
                clk_lost_ff <= 1'b0;
            end
            if (lock_lost_evt) begin
                lock_lost_ff <= 1'b1;
            end else if (clr_irq) begin
                lock_lost_ff <= 1'b0;
            end
            if ((clk_lost_evt && !ctrl2_ff.loss_rst_en) || (lock_lost_evt && !ctrl2_ff.lock_rst_en)) begin
                irq_ff <= 1'b1;
            end else if (clr_irq) begin
                irq_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reset_req_ff <= 1'b0;
        end else if (ce) begin
            reset_req_ff <= (clk_lost_evt && ctrl2_ff.loss_rst_en) || (lock_lost_evt && ctrl2_ff.lock_rst_en);
        end
    end

    always_comb begin
        stat1 = 8'h00;
        stat1[S1_MODE_HI:S1_MODE_LO] = mode_ff;
        stat1[S1_REF_EXT] = ctrl1_ff.ext_sel;
        stat1[S1_CLK_LOST] = clk_lost_ff;
        stat1[S1_LOCKED] = locked_ff;
        stat1[S1_LOCK_LOST] = lock_lost_ff;
        stat1[S1_IRQ] = irq_ff;
        stat2 = 8'h00;
        stat2[S2_OSC_STABLE] = osc_stable;
    end

    // ****************************************
    // Output divider and bus clock
    // ****************************************
    logic [7:0] rdiv_cnt_ff;
    logic out_clk_ff;
    logic bus_clk_ff;
    logic src_tick;

    // Bypassed external mode takes ticks straight from the reference edges.
    assign src_tick = (mode_ff == MODE_BYPX) ? ext_edge : dco_tick;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdiv_cnt_ff <= 8'h00;
            out_clk_ff <= 1'b0;
            bus_clk_ff <= 1'b0;
        end else if (ce && src_tick) begin
            if (rdiv_cnt_ff >= div_factor(ctrl2_ff.div_code) - 8'h01) begin
                rdiv_cnt_ff <= 8'h00;
                out_clk_ff <= !out_clk_ff;
                if (!out_clk_ff) begin
                    bus_clk_ff <= !bus_clk_ff;
                end
            end else begin
                rdiv_cnt_ff <= rdiv_cnt_ff + 8'h01;
            end
        end
    end

    assign generator_output_clock = out_clk_ff;
    assign bus_clock = bus_clk_ff;
    assign irq_req = irq_ff;
    assign reset_req = reset_req_ff;
    assign high_gain_select = ctrl1_ff.gain_hi && ctrl1_ff.ext_sel;
    assign osc_range_high = ctrl1_ff.range_hi;
    assign oscillator_enable = ctrl1_ff.ext_sel && (ctrl1_ff.mode_sel[1] || ctrl1_ff.osc_keep);
endmodule
`default_nettype wire

// ===== bench/cg_ext_ref_model.sv
// Behavioural external reference clock source for the FLL clock generator.
`timescale 1ns/1ns
`default_nettype none
module cg_ext_ref_model (
    input wire logic run,
    input wire logic [15:0] half_ns,
    output logic ref_out
);
    // A stopped source holds its line low, as a halted crystal does.
    initial begin
        ref_out = 1'b0;
        forever begin
            if (run === 1'b1) begin
                #(half_ns) ref_out = ~ref_out;
            end else begin
                ref_out = 1'b0;
                wait (run === 1'b1);
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/cg_fll_clock_gen_sva.sv
// Checker of register and output relations for the FLL clock generator.
`timescale 1ns/1ns
`default_nettype none
module cg_fll_clock_gen_sva
    import cg_pkg::*;
#(
    parameter int LOC_TIMEOUT = LOC_CYC,
    parameter int ACC_W = 16
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rdata,
    input wire logic ext_ref_pin,
    input wire logic generator_output_clock,
    input wire logic bus_clock,
    input wire logic oscillator_enable,
    input wire logic high_gain_select,
    input wire logic osc_range_high,
    input wire logic irq_req,
    input wire logic reset_req
);
    logic [7:0] ctl_ff;
    logic gain_done_ff;
    logic [3:0] age_ff;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // ****************************************
    // Shadow of control one and mode age
    // ****************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctl_ff <= CTRL1_RST;
            gain_done_ff <= 1'b0;
        end else if (ce && wr_stb && addr == ADDR_CTRL1) begin
            ctl_ff[6:0] <= wdata[6:0];
            if (!gain_done_ff) begin
                ctl_ff[7] <= wdata[7];
            end
            gain_done_ff <= 1'b1;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            age_ff <= 4'hf;
        end else if (ce && wr_stb && addr == ADDR_CTRL1 && wdata[4:3] != ctl_ff[4:3]) begin
            age_ff <= 4'h0;
        end else if (ce && age_ff != 4'hf) begin
            age_ff <= age_ff + 4'h1;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    osc_enable_a: assert property (oscillator_enable == (ctl_ff[5] && (ctl_ff[4] || ctl_ff[2])))
        else $error("oscillator enable differs from control one");
    range_sel_a: assert property (osc_range_high == ctl_ff[6])
        else $error("range output differs from control one");
    gain_once_a: assert property (high_gain_select == (ctl_ff[7] && ctl_ff[5]))
        else $error("gain select took a second write");
    ctrl1_read_a: assert property (ce && rd_stb && addr == ADDR_CTRL1 |=> rdata == {ctl_ff[7:1], 1'b0})
        else $error("control one read back wrong");
    ctrl2_back_a: assert property (ce && wr_stb && addr == ADDR_CTRL2 ##2 ce && rd_stb && addr == ADDR_CTRL2
        |=> rdata == $past(wdata, 3)) else $error("control two read back wrong");
    mode_state_a: assert property (ce && rd_stb && addr == ADDR_STAT1 && ctl_ff[4] == 1'b0 && age_ff > 4'h5
        |=> rdata[7:6] == $past(ctl_ff[4:3])) else $error("mode state not settled");
    irq_clear_a: assert property (ce && wr_stb && addr == ADDR_STAT1 && wdata[S1_IRQ] |=> !irq_req)
        else $error("interrupt flag not cleared");
    reset_pulse_a: assert property (reset_req |=> !reset_req)
        else $error("reset request longer than one cycle");
endmodule
bind cg_fll_clock_gen cg_fll_clock_gen_sva #(.LOC_TIMEOUT(LOC_TIMEOUT), .ACC_W(ACC_W)) u_sva (.clk_sys(clk_sys),
    .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .ext_ref_pin(ext_ref_pin), .generator_output_clock(generator_output_clock), .bus_clock(bus_clock),
    .oscillator_enable(oscillator_enable), .high_gain_select(high_gain_select),
    .osc_range_high(osc_range_high), .irq_req(irq_req), .reset_req(reset_req));
`default_nettype wire

// ===== bench/tb_cg_fll_clock_gen.sv
// Self-checking testbench for the FLL clock generator.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got %h expected %h", $time, (g), (e)); end end
module tb_cg_fll_clock_gen import cg_pkg::*;;
    logic clk_sys, rstn, ce, wr_stb, rd_stb, gen_clk, bus_clk, osc_en, hgo_out, range_out, irq, rreq;
    logic ext_ref, ref_run, rr_seen;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, got;
    logic [15:0] ref_half;
    int bad_count, samples_checked, n_gen, n_bus;
    cg_fll_clock_gen #(.LOC_TIMEOUT(2000)) DUT (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ext_ref_pin(ext_ref),
        .generator_output_clock(gen_clk), .bus_clock(bus_clk), .oscillator_enable(osc_en),
        .high_gain_select(hgo_out), .osc_range_high(range_out), .irq_req(irq), .reset_req(rreq));
    cg_ext_ref_model u_ref (.run(ref_run), .half_ns(ref_half), .ref_out(ext_ref));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (rreq === 1'b1) rr_seen <= 1'b1;
    end
    // ****************************************
    // Bus and measurement helpers
    // ****************************************
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a; wdata <= d; wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys);
        addr <= a; rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic count(input int cyc);
        logic pg, pb;
        n_gen = 0; n_bus = 0; pg = gen_clk; pb = bus_clk;
        repeat (cyc) begin
            @(posedge clk_sys);
            #1;
            if (gen_clk === 1'b1 && pg === 1'b0) n_gen++;
            if (bus_clk === 1'b1 && pb === 1'b0) n_bus++;
            pg = gen_clk; pb = bus_clk;
        end
    endtask
    function automatic logic near(input int n, input real e, input real tol);
        return (n > e * (1.0 - tol)) && (n < e * (1.0 + tol));
    endfunction
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic check_reset;
        logic [2:0] ra[6] = '{ADDR_CTRL1, ADDR_CTRL2, ADDR_FILT_HI, ADDR_FILT_LO, ADDR_TRIM, 3'h7};
        logic [7:0] rv[6] = '{8'h00, 8'h00, {4'h0, FILTER_RST[11:8]}, FILTER_RST[7:0], TRIM_RST, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd(ra[i]);
            `CHK(got, rv[i])
        end
        rd(ADDR_STAT1);
        `CHK(got[7:6], MODE_SELF)
        count(1000);
        `CHK(near(n_gen, 1000.0 * 8.0 / CLK_MHZ, 0.25), 1'b1)
        `CHK((n_bus * 2 - n_gen) inside {[-2:2]}, 1'b1)
    endtask
    task automatic check_regs;
        logic [7:0] c2v[3] = '{8'hff, 8'h88, 8'h31};
        wr(ADDR_CTRL1, 8'h25);
        rd(ADDR_CTRL1);
        `CHK(got, 8'h24)
        `CHK(osc_en, 1'b1)
        `CHK(hgo_out, 1'b0)
        wr(ADDR_CTRL1, 8'hc1);
        rd(ADDR_CTRL1);
        `CHK(got, 8'h40)
        `CHK(range_out, 1'b1)
        `CHK(osc_en, 1'b0)
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL2, c2v[i]);
            rd(ADDR_CTRL2);
            `CHK(got, c2v[i])
        end
        @(posedge clk_sys) ce <= 1'b0;
        wr(ADDR_CTRL2, 8'h55);
        @(posedge clk_sys) ce <= 1'b1;
        rd(ADDR_CTRL2);
        `CHK(got, 8'h31)
        wr(ADDR_FILT_HI, 8'hff);
        rd(ADDR_FILT_HI);
        `CHK(got, 8'h0f)
        wr(ADDR_FILT_HI, {4'h0, FILTER_RST[11:8]});
        wr(ADDR_TRIM, 8'he0);
        rd(ADDR_TRIM);
        `CHK(got, 8'he0)
        wr(ADDR_STAT1, 8'hc0);
        rd(ADDR_STAT1);
        `CHK(got[7:6], MODE_SELF)
    endtask
    task automatic check_fei;
        wr(ADDR_CTRL2, 8'h00);
        wr(ADDR_CTRL1, 8'h08);
        rd(ADDR_STAT1);
        `CHK(got[7:6], MODE_SELF)
        repeat (12000) @(posedge clk_sys);
        rd(ADDR_STAT1);
        `CHK(got[7:6], MODE_LPINT)
        count(4000);
        `CHK(near(n_gen, 4000.0 * PRESCALE_LOW * 4 / (IREF_DIV * (IREF_NOM_CYC + 24)), 0.1), 1'b1)
    endtask
    task automatic check_fee;
        int half[5] = '{250, 250, 625, 1125, 16000};
        int pn[5] = '{4, 4, 10, 18, 256};
        int rr[5] = '{1, 2, 4, 1, 1};
        logic [7:0] c2[5] = '{8'h00, 8'h01, 8'h32, 8'h70, 8'h00};
        logic [7:0] c1[5] = '{8'h78, 8'h78, 8'h78, 8'h78, 8'h38};
        for (int i = 0; i < 5; i++) begin
            ref_half <= half[i][15:0];
            ref_run <= 1'b1;
            wr(ADDR_CTRL2, c2[i]);
            wr(ADDR_CTRL1, c1[i]);
            repeat (3000) @(posedge clk_sys);
            rd(ADDR_STAT1);
            `CHK(got[7:6], MODE_LPEXT)
            rd(ADDR_STAT2);
            `CHK(got[S2_OSC_STABLE], 1'b1)
            count(2000);
            `CHK(near(n_gen, 2000.0 * 20 * pn[i] / (2.0 * half[i] * rr[i]), 0.1), 1'b1)
        end
    endtask
    task automatic check_loss;
        ref_run <= 1'b0;
        wr(ADDR_CTRL1, 8'h00);
        wr(ADDR_STAT1, 8'h01);
        #1 `CHK(irq, 1'b0)
        rr_seen = 1'b0;
        wr(ADDR_CTRL1, 8'h78);
        repeat (2100) @(posedge clk_sys);
        #1 `CHK(irq, 1'b1)
        rd(ADDR_STAT1);
        `CHK(got[S1_CLK_LOST], 1'b1)
        `CHK(rr_seen, 1'b0)
        wr(ADDR_CTRL1, 8'h00);
        wr(ADDR_STAT1, 8'h01);
        wr(ADDR_CTRL1, 8'h7a);
        repeat (2100) @(posedge clk_sys);
        #1 `CHK(irq, 1'b0)
        wr(ADDR_CTRL1, 8'h00);
        wr(ADDR_CTRL2, 8'h08);
        wr(ADDR_CTRL1, 8'h78);
        repeat (2100) @(posedge clk_sys);
        #1 `CHK(rr_seen, 1'b1)
        `CHK(irq, 1'b0)
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        bad_count++;
        close_out;
    end
    initial begin
        rstn = 1'b0; ce = 1'b1; addr = 3'h0; wdata = 8'h00; wr_stb = 1'b0; rd_stb = 1'b0;
        ref_run = 1'b0; ref_half = 16'd250; rr_seen = 1'b0; bad_count = 0; samples_checked = 0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        check_reset;
        check_regs;
        check_fei;
        check_fee;
        check_loss;
        close_out;
    end
endmodule
`default_nettype wire
